// File: dift_pkg.sv
// Purpose: Shared constants for the IF packet transport framer
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register port
// Notes:   Offsets are byte addresses of aligned 32-bit words
package dift_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CTX_RATE_HZ = 10;
  localparam int unsigned CTX_PERIOD_CYC = CLK_HZ / CTX_RATE_HZ;
  localparam int unsigned VER_RATE_MAX = 100;
  localparam int unsigned VER_TICK_CYC = CLK_HZ / VER_RATE_MAX;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_OWN_MAC_HI = 8'h08;
  localparam logic [7:0] REG_OWN_MAC_LO = 8'h0C;
  localparam logic [7:0] REG_OWN_IP = 8'h10;
  localparam logic [7:0] REG_MC_MAC_HI = 8'h14;
  localparam logic [7:0] REG_MC_MAC_LO = 8'h18;
  localparam logic [7:0] REG_MC_IP = 8'h1C;
  localparam logic [7:0] REG_DST_IP = 8'h20;
  localparam logic [7:0] REG_TX_PORTS = 8'h24;
  localparam logic [7:0] REG_RX_PORT = 8'h28;
  localparam logic [7:0] REG_VER_RATE = 8'h2C;
  localparam logic [7:0] REG_RX_DROPS = 8'h30;

  // Control fields
  localparam int unsigned CTRL_TX_EN = 0;
  localparam int unsigned CTRL_MCAST = 1;
  localparam int unsigned CTRL_RX_EN = 2;

  // Status fields
  localparam int unsigned STAT_ARP_OK = 0;
  localparam int unsigned STAT_CTX_SEEN = 1;
  localparam int unsigned STAT_SEQ_LSB = 4;

  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam logic [15:0] UDP_PORT_RST = 16'hC350;
  localparam logic [15:0] UDP_PORT_MIN = 16'h0400;
  localparam logic [6:0] VER_RATE_RST = 7'h00;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int unsigned HDR_BYTES = 42;
  localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
  localparam logic [7:0] IP_VER_IHL = 8'h45;
  localparam logic [15:0] IP_FLAGS_DF = 16'h4000;
  localparam logic [7:0] IP_TTL = 8'h40;
  localparam logic [7:0] IP_PROTO_UDP = 8'h11;
  localparam logic [15:0] IP_HDR_LEN = 16'h0014;
  localparam logic [15:0] UDP_HDR_LEN = 16'h0008;
  localparam logic [23:0] MC_MAC_PREFIX = 24'h01005E;
  localparam logic [3:0] VRT_CTX_TYPE = 4'h4;
  localparam logic [1:0] CTX_TYPE_STD = 2'h0;
  localparam logic [1:0] CTX_TYPE_VER = 2'h1;

  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_PAY} dift_tx_st_t;

endpackage : dift_pkg

// File: dift_framer.sv
// Purpose: UDP/IPv4/Ethernet framing and filtering for IF packet transport
// Assumes: Byte streams, one byte per cycle; network side always accepts
// Notes:   ARP itself runs outside; this block only requests and learns
//
// Overview of operation
// - Unicast destination MAC is learned by ARP at each enable.
// - Multicast destination MAC comes from the IP; no ARP.
// - Received frames need own or multicast destination MAC.
// - Outbound IPv4 header checksum is inserted here.
// - Received frames need own or multicast destination IP.
// - UDP source port resets to 50000, settable 1024-65535.
// - UDP destination port resets to 50000, settable 1024-65535.
// - Listening UDP port resets to 50000, settable 1024-65535.
// - Any inbound UDP source port is accepted.
// - UDP length is payload plus eight header bytes.
// - Ten standard context packets per second outbound.
// - Version packet rate is set 0 (off) to 100; ver ticks on a context tick are skipped, so 100 gives 90 per second.
// - Inbound data reaches RF only after a context packet.
// - Untagged Ethernet frames carry IPv4 then UDP headers.
// - No trailers or extra transport framing.
// - Samples complex signed, I and Q 4 to 16 bits.
// - Standard flow bandwidth 10 kHz to 600 MHz.
// - Standard flow context type 0, version flow type 1.
// - 4-bit sequence counts standard context packets modulo 16.
`timescale 1ns/100ps
module dift_framer
  import dift_pkg::*;
#(
  parameter int unsigned CTX_PERIOD = dift_pkg::CTX_PERIOD_CYC,
  parameter int unsigned VER_TICK = dift_pkg::VER_TICK_CYC
)(
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic ARP_REQ_O,
  output logic [31:0] ARP_IP_O,
  input wire logic ARP_DONE_I,
  input wire logic [47:0] ARP_MAC_I,
  output logic CTX_REQ_O,
  output logic [1:0] CTX_TYPE_O,
  output logic [3:0] CTX_SEQ_O,
  input wire logic [7:0] TX_PL_DATA_I,
  input wire logic TX_PL_VALID_I,
  input wire logic TX_PL_LAST_I,
  input wire logic [15:0] TX_PL_LEN_I,
  output logic TX_PL_READY_O,
  output logic [7:0] ETH_TX_DATA_O,
  output logic ETH_TX_VALID_O,
  output logic ETH_TX_LAST_O,
  input wire logic [7:0] ETH_RX_DATA_I,
  input wire logic ETH_RX_VALID_I,
  input wire logic ETH_RX_LAST_I,
  output logic [7:0] RX_PL_DATA_O,
  output logic RX_PL_VALID_O,
  output logic RX_PL_LAST_O,
  output logic RX_PL_CTX_O
);
  import dift_pkg::*;

  initial
  begin
    if (CTX_PERIOD < 2 || VER_TICK < 2)
      $error("rate periods below 2 cycles");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] wr_bytes(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction : wr_bytes

  function automatic logic port_ok(input logic [15:0] p);
    return p >= UDP_PORT_MIN;
  endfunction : port_ok

  // Ones-complement sum of ten header words, folded and inverted
  function automatic logic [15:0] ip_csum(input logic [159:0] h);
    logic [19:0] s;
    s = 20'h00000;
    for (int i = 0; i < 10; i++)
      s = s + {4'h0, h[16*i +: 16]};
    s = {4'h0, s[15:0]} + {16'h0000, s[19:16]};
    s = {4'h0, s[15:0]} + {16'h0000, s[19:16]};
    return ~s[15:0];
  endfunction : ip_csum

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [2:0] ctrl_q;
  logic [47:0] own_mac_q;
  logic [31:0] own_ip_q;
  logic [47:0] mc_mac_q;
  logic [31:0] mc_ip_q;
  logic [31:0] dst_ip_q;
  logic [15:0] tx_sport_q;
  logic [15:0] tx_dport_q;
  logic [15:0] rx_port_q;
  logic [6:0] ver_rate_q;
  logic [31:0] rx_drops_q;
  logic arp_ok_q;
  logic ctx_seen_q;
  logic [3:0] seq_q;
  logic wb_req;
  logic wb_wr;
  logic [31:0] wd;

  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr = wb_req && WB_WE_I;

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      ctrl_q <= 3'h0;
      own_mac_q <= 48'h000000000000;
      own_ip_q <= 32'h00000000;
      mc_mac_q <= 48'h000000000000;
      mc_ip_q <= 32'h00000000;
      dst_ip_q <= 32'h00000000;
      tx_sport_q <= UDP_PORT_RST;
      tx_dport_q <= UDP_PORT_RST;
      rx_port_q <= UDP_PORT_RST;
      ver_rate_q <= VER_RATE_RST;
    end
    else if (wb_wr)
    begin
      unique case (WB_ADR_I)
        REG_CTRL:
          ctrl_q <= wd[2:0];
        REG_OWN_MAC_HI:
          own_mac_q[47:32] <= wd[15:0];
        REG_OWN_MAC_LO:
          own_mac_q[31:0] <= wr_bytes(own_mac_q[31:0], WB_DAT_I, WB_SEL_I);
        REG_OWN_IP:
          own_ip_q <= wr_bytes(own_ip_q, WB_DAT_I, WB_SEL_I);
        REG_MC_MAC_HI:
          mc_mac_q[47:32] <= wd[15:0];
        REG_MC_MAC_LO:
          mc_mac_q[31:0] <= wr_bytes(mc_mac_q[31:0], WB_DAT_I, WB_SEL_I);
        REG_MC_IP:
          mc_ip_q <= wr_bytes(mc_ip_q, WB_DAT_I, WB_SEL_I);
        REG_DST_IP:
          dst_ip_q <= wr_bytes(dst_ip_q, WB_DAT_I, WB_SEL_I);
        REG_TX_PORTS:
        begin
          // Out-of-range port writes are ignored, the old value stays
          if (port_ok(wd[31:16]))
            tx_sport_q <= wd[31:16];
          if (port_ok(wd[15:0]))
            tx_dport_q <= wd[15:0];
        end
        REG_RX_PORT:
          if (port_ok(wd[15:0]))
            rx_port_q <= wd[15:0];
        REG_VER_RATE:
          if (wd[6:0] <= 7'(VER_RATE_MAX))
            ver_rate_q <= wd[6:0];
        default:
          ;
      endcase
    end
  end

  always_comb
  begin
    unique case (WB_ADR_I)
      REG_CTRL: wd = wr_bytes({29'h0, ctrl_q}, WB_DAT_I, WB_SEL_I);
      REG_OWN_MAC_HI: wd = wr_bytes({16'h0, own_mac_q[47:32]}, WB_DAT_I,
        WB_SEL_I);
      REG_MC_MAC_HI: wd = wr_bytes({16'h0, mc_mac_q[47:32]}, WB_DAT_I,
        WB_SEL_I);
      REG_TX_PORTS: wd = wr_bytes({tx_sport_q, tx_dport_q}, WB_DAT_I,
        WB_SEL_I);
      REG_RX_PORT: wd = wr_bytes({16'h0, rx_port_q}, WB_DAT_I, WB_SEL_I);
      REG_VER_RATE: wd = wr_bytes({25'h0, ver_rate_q}, WB_DAT_I, WB_SEL_I);
      default: wd = WB_DAT_I;
    endcase
  end

  // Single-wait-state slave; unmapped reads return zero
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else
    begin
      WB_ACK_O <= wb_req;
      if (wb_req && !WB_WE_I)
        unique case (WB_ADR_I)
          REG_CTRL: WB_DAT_O <= {29'h0, ctrl_q};
          REG_STATUS: WB_DAT_O <= {24'h0, seq_q, 2'h0, ctx_seen_q,
            arp_ok_q};
          REG_OWN_MAC_HI: WB_DAT_O <= {16'h0, own_mac_q[47:32]};
          REG_OWN_MAC_LO: WB_DAT_O <= own_mac_q[31:0];
          REG_OWN_IP: WB_DAT_O <= own_ip_q;
          REG_MC_MAC_HI: WB_DAT_O <= {16'h0, mc_mac_q[47:32]};
          REG_MC_MAC_LO: WB_DAT_O <= mc_mac_q[31:0];
          REG_MC_IP: WB_DAT_O <= mc_ip_q;
          REG_DST_IP: WB_DAT_O <= dst_ip_q;
          REG_TX_PORTS: WB_DAT_O <= {tx_sport_q, tx_dport_q};
          REG_RX_PORT: WB_DAT_O <= {16'h0, rx_port_q};
          REG_VER_RATE: WB_DAT_O <= {25'h0, ver_rate_q};
          REG_RX_DROPS: WB_DAT_O <= rx_drops_q;
          default: WB_DAT_O <= 32'h00000000;
        endcase
      else
        WB_DAT_O <= 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Destination MAC resolution
  // ---------------------------------------------------------------
  logic tx_en_q;
  logic [47:0] dst_mac_q;
  logic [47:0] dst_mac;

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      tx_en_q <= 1'b0;
      arp_ok_q <= 1'b0;
      dst_mac_q <= 48'h000000000000;
      ARP_REQ_O <= 1'b0;
      ARP_IP_O <= 32'h00000000;
    end
    else
    begin
      tx_en_q <= ctrl_q[CTRL_TX_EN];
      // Every enable edge forgets the old MAC; ARP asks again only when multicast is off
      ARP_REQ_O <= ctrl_q[CTRL_TX_EN] && !tx_en_q &&
        !ctrl_q[CTRL_MCAST];
      ARP_IP_O <= dst_ip_q;
      if (ctrl_q[CTRL_TX_EN] && !tx_en_q)
        arp_ok_q <= 1'b0;
      else if (ARP_DONE_I && tx_en_q)
      begin
        arp_ok_q <= 1'b1;
        dst_mac_q <= ARP_MAC_I;
      end
    end
  end

  // Multicast MAC maps the low 23 IP bits behind a fixed prefix
  assign dst_mac = ctrl_q[CTRL_MCAST] ?
    {MC_MAC_PREFIX, 1'b0, dst_ip_q[22:0]} : dst_mac_q;

  // ---------------------------------------------------------------
  // Context packet scheduling
  // ---------------------------------------------------------------
  logic [31:0] ctx_cnt_q;
  logic [31:0] ver_cnt_q;
  logic [7:0] ver_acc_q;
  logic ctx_tick;
  logic ver_tick;

  assign ctx_tick = ctx_cnt_q == 32'(CTX_PERIOD - 1);
  assign ver_tick = ver_cnt_q == 32'(VER_TICK - 1);

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I || !ctrl_q[CTRL_TX_EN])
    begin
      ctx_cnt_q <= 32'h00000000;
      ver_cnt_q <= 32'h00000000;
      ver_acc_q <= 8'h00;
      seq_q <= 4'h0;
      CTX_REQ_O <= 1'b0;
      CTX_TYPE_O <= CTX_TYPE_STD;
      CTX_SEQ_O <= 4'h0;
    end
    else
    begin
      ctx_cnt_q <= ctx_tick ? 32'h00000000 : ctx_cnt_q + 32'h1;
      ver_cnt_q <= ver_tick ? 32'h00000000 : ver_cnt_q + 32'h1;
      CTX_REQ_O <= 1'b0;
      if (ctx_tick)
      begin
        CTX_REQ_O <= 1'b1;
        CTX_TYPE_O <= CTX_TYPE_STD;
        CTX_SEQ_O <= seq_q;
        seq_q <= seq_q + 4'h1;
      end
      else if (ver_tick)
      begin
        // Rate accumulator: ver_rate_q packets per hundred ticks
        if (ver_acc_q + {1'b0, ver_rate_q} >= 8'(VER_RATE_MAX))
        begin
          ver_acc_q <= ver_acc_q + {1'b0, ver_rate_q} -
            8'(VER_RATE_MAX);
          CTX_REQ_O <= 1'b1;
          CTX_TYPE_O <= CTX_TYPE_VER;
        end
        else
          ver_acc_q <= ver_acc_q + {1'b0, ver_rate_q};
      end
    end
  end

  // ---------------------------------------------------------------
  // Outbound framer
  // ---------------------------------------------------------------
  dift_tx_st_t tx_st_q;
  logic [8*HDR_BYTES-1:0] hdr_q;
  logic [8*HDR_BYTES-1:0] hdr;
  logic [5:0] hdr_cnt_q;
  logic [15:0] udp_len;
  logic [15:0] ip_len;
  logic [159:0] ip_hdr;

  assign udp_len = TX_PL_LEN_I + UDP_HDR_LEN;
  assign ip_len = udp_len + IP_HDR_LEN;

  always_comb
  begin
    ip_hdr = {IP_VER_IHL, 8'h00, ip_len, 16'h0000, IP_FLAGS_DF, IP_TTL,
      IP_PROTO_UDP, 16'h0000, own_ip_q, dst_ip_q};
    ip_hdr[79:64] = ip_csum(ip_hdr);
    // Untagged Ethernet, IPv4, UDP; nothing follows the payload
    hdr = {dst_mac, own_mac_q, ETYPE_IPV4, ip_hdr, tx_sport_q, tx_dport_q,
      udp_len, 16'h0000};
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      tx_st_q <= TX_IDLE;
      hdr_q <= '0;
      hdr_cnt_q <= 6'h00;
      TX_PL_READY_O <= 1'b0;
      ETH_TX_DATA_O <= 8'h00;
      ETH_TX_VALID_O <= 1'b0;
      ETH_TX_LAST_O <= 1'b0;
    end
    else
    begin
      ETH_TX_VALID_O <= 1'b0;
      ETH_TX_LAST_O <= 1'b0;
      unique case (tx_st_q)
        TX_IDLE:
          // Unicast frames wait until the ARP MAC is known; multicast frames do not
          if (TX_PL_VALID_I && ctrl_q[CTRL_TX_EN] &&
            (arp_ok_q || ctrl_q[CTRL_MCAST]))
          begin
            hdr_q <= hdr;
            hdr_cnt_q <= 6'h00;
            tx_st_q <= TX_HDR;
          end
        TX_HDR:
        begin
          ETH_TX_DATA_O <= hdr_q[8*HDR_BYTES-1 -: 8];
          ETH_TX_VALID_O <= 1'b1;
          hdr_q <= hdr_q << 8;
          hdr_cnt_q <= hdr_cnt_q + 6'h01;
          if (hdr_cnt_q == 6'(HDR_BYTES - 1))
          begin
            tx_st_q <= TX_PAY;
            TX_PL_READY_O <= 1'b1;
          end
        end
        TX_PAY:
          if (TX_PL_VALID_I)
          begin
            ETH_TX_DATA_O <= TX_PL_DATA_I;
            ETH_TX_VALID_O <= 1'b1;
            ETH_TX_LAST_O <= TX_PL_LAST_I;
            if (TX_PL_LAST_I)
            begin
              TX_PL_READY_O <= 1'b0;
              tx_st_q <= TX_IDLE;
            end
          end
        default:
          tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Inbound filter
  // ---------------------------------------------------------------
  logic [8*HDR_BYTES-9:0] rx_hdr_q;
  logic [8*HDR_BYTES-1:0] rx_hdr;
  logic [5:0] rx_cnt_q;
  logic rx_pass_q;
  logic rx_first_q;
  logic rx_is_ctx_q;
  logic rx_hdr_end;
  logic rx_match;
  logic rx_is_ctx;

  assign rx_hdr = {rx_hdr_q, ETH_RX_DATA_I};
  assign rx_hdr_end = ETH_RX_VALID_I && rx_cnt_q == 6'(HDR_BYTES - 1);
  // Source MAC, IP, port and checksum are not checked here
  assign rx_match =
    (rx_hdr[335:288] == own_mac_q || rx_hdr[335:288] == mc_mac_q) &&
    rx_hdr[239:224] == ETYPE_IPV4 && rx_hdr[223:216] == IP_VER_IHL &&
    rx_hdr[151:144] == IP_PROTO_UDP &&
    (rx_hdr[95:64] == own_ip_q || rx_hdr[95:64] == mc_ip_q) &&
    rx_hdr[47:32] == rx_port_q;
  assign rx_is_ctx = ETH_RX_DATA_I[7:4] == VRT_CTX_TYPE;

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      rx_hdr_q <= '0;
      rx_cnt_q <= 6'h00;
      rx_pass_q <= 1'b0;
      rx_first_q <= 1'b0;
      rx_is_ctx_q <= 1'b0;
      rx_drops_q <= 32'h00000000;
      ctx_seen_q <= 1'b0;
      RX_PL_DATA_O <= 8'h00;
      RX_PL_VALID_O <= 1'b0;
      RX_PL_LAST_O <= 1'b0;
      RX_PL_CTX_O <= 1'b0;
    end
    else
    begin
      RX_PL_VALID_O <= 1'b0;
      RX_PL_LAST_O <= 1'b0;
      if (!ctrl_q[CTRL_RX_EN])
        ctx_seen_q <= 1'b0;
      if (ETH_RX_VALID_I)
      begin
        if (rx_cnt_q != 6'(HDR_BYTES))
        begin
          rx_hdr_q <= rx_hdr[8*HDR_BYTES-9:0];
          rx_cnt_q <= rx_cnt_q + 6'h01;
        end
        if (rx_hdr_end)
        begin
          rx_pass_q <= rx_match && ctrl_q[CTRL_RX_EN];
          rx_first_q <= 1'b1;
          if (!rx_match)
            rx_drops_q <= rx_drops_q + 32'h1;
        end
        else if (rx_cnt_q == 6'(HDR_BYTES) && rx_pass_q)
        begin
          rx_first_q <= 1'b0;
          if (rx_first_q)
          begin
            rx_is_ctx_q <= rx_is_ctx;
            if (rx_is_ctx)
              ctx_seen_q <= 1'b1;
          end
          // Data before any context is dropped, not converted to RF
          if ((rx_first_q ? rx_is_ctx : rx_is_ctx_q) ||
            ctx_seen_q)
          begin
            RX_PL_DATA_O <= ETH_RX_DATA_I;
            RX_PL_VALID_O <= 1'b1;
            RX_PL_LAST_O <= ETH_RX_LAST_I;
            RX_PL_CTX_O <= rx_first_q ? rx_is_ctx : rx_is_ctx_q;
          end
        end
        if (ETH_RX_LAST_I)
        begin
          // Runt frames count as drops too
          if (rx_cnt_q < 6'(HDR_BYTES - 1))
            rx_drops_q <= rx_drops_q + 32'h1;
          rx_cnt_q <= 6'h00;
          rx_pass_q <= 1'b0;
          rx_first_q <= 1'b0;
        end
      end
    end
  end

endmodule : dift_framer

// File: dift_chk.sv
// Purpose: Port checker for the IF packet framer
// Assumes: Single clock, synchronous active-high reset
// Notes:   Helper clears its context history on every control write
`timescale 1ns/100ps
module dift_chk
  import dift_pkg::*;
#(
  parameter int unsigned CTX_PERIOD = CTX_PERIOD_CYC,
  parameter int unsigned VER_TICK = VER_TICK_CYC
)(
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic ARP_REQ_O,
  input wire logic CTX_REQ_O,
  input wire logic [1:0] CTX_TYPE_O,
  input wire logic [3:0] CTX_SEQ_O,
  input wire logic TX_PL_READY_O,
  input wire logic ETH_TX_VALID_O,
  input wire logic ETH_TX_LAST_O,
  input wire logic RX_PL_VALID_O,
  input wire logic RX_PL_LAST_O
);
  logic seen_q;
  logic [3:0] seq_q;
  logic [31:0] gap_q;
  logic std_w;
  assign std_w = CTX_REQ_O && CTX_TYPE_O == CTX_TYPE_STD;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  // Enable toggles may restart the stream, so history is dropped
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I || (WB_ACK_O && WB_WE_I && WB_ADR_I == REG_CTRL))
      seen_q <= 1'b0;
    else if (std_w)
      seen_q <= 1'b1;
    gap_q <= std_w ? 32'h0 : gap_q + 32'h1;
    if (std_w)
      seq_q <= CTX_SEQ_O;
  end
  chk_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  chk_rdata_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data not zero");
  chk_arp_pulse: assert property (ARP_REQ_O |=> !ARP_REQ_O)
    else $error("ARP request too long");
  chk_ctx_seq: assert property (std_w && seen_q |-> CTX_SEQ_O == seq_q + 4'h1)
    else $error("sequence skip");
  chk_ctx_gap: assert property (std_w && seen_q |-> gap_q == CTX_PERIOD - 1)
    else $error("context spacing wrong");
  chk_ctx_type: assert property (CTX_REQ_O |-> CTX_TYPE_O inside {2'h0, 2'h1})
    else $error("bad context type");
  chk_hdr_run: assert property ($rose(ETH_TX_VALID_O) && !TX_PL_READY_O |-> (ETH_TX_VALID_O && !TX_PL_READY_O)[*8])
    else $error("header run broken");
  chk_tx_end: assert property (ETH_TX_LAST_O |-> ETH_TX_VALID_O && !TX_PL_READY_O)
    else $error("frame end malformed");
  chk_rx_last: assert property (RX_PL_LAST_O |-> RX_PL_VALID_O)
    else $error("last without valid");
  cov_arp: cover property (ARP_REQ_O);
  cov_ver: cover property (CTX_REQ_O && CTX_TYPE_O == CTX_TYPE_VER);
  cov_tx: cover property (ETH_TX_LAST_O);
  cov_rx: cover property (RX_PL_LAST_O);
endmodule : dift_chk
bind dift_framer dift_chk #(.CTX_PERIOD(CTX_PERIOD), .VER_TICK(VER_TICK))
  i_chk (.*);

// File: dift_peer.sv
// Purpose: Network peer model answering address requests and sending frames
// Assumes: Frames handed in whole, 46 bytes, first byte leftmost
// Notes:   Released lines show inverted data
`timescale 1ns/100ps
module dift_peer #(
  parameter logic [47:0] PEER_MAC = 48'h025A00000007
)(
  input wire logic clk_i,
  input wire logic arp_req_i,
  output logic arp_done_o,
  output logic [47:0] arp_mac_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_last_o
);
  initial
  begin
    arp_done_o = 1'b0;
    arp_mac_o = ~PEER_MAC;
    rx_data_o = 8'hA5;
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
  end
  always @(posedge clk_i)
    if (arp_req_i)
    begin
      repeat (3) @(posedge clk_i);
      arp_done_o <= 1'b1;
      arp_mac_o <= PEER_MAC;
      @(posedge clk_i);
      arp_done_o <= 1'b0;
      arp_mac_o <= ~PEER_MAC;
    end
  // Same source MAC and IP in every frame, sender fills checksum
  task automatic send(input logic [367:0] v);
    for (int i = 0; i < 46; i++)
    begin
      rx_data_o <= v[367-8*i -: 8];
      rx_valid_o <= 1'b1;
      rx_last_o <= (i == 45);
      @(posedge clk_i);
    end
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    rx_data_o <= ~v[7:0];
    repeat (4) @(posedge clk_i);
  endtask : send
endmodule : dift_peer

// File: dift_framer_tb.sv
// Purpose: Register, framing, filtering and rate tests for the framer
// Assumes: Short context periods via parameters
// Notes:   Mid-run reset separates the rate phase
`timescale 1ns/100ps
module dift_framer_tb;
  import dift_pkg::*;
  logic clk, rst, cyc, stb, we, ack, arp_req, arp_done, ctx_req;
  logic pv, pl, ready, txv, txl, rxv, rxl, rpv, rpl, rpc;
  logic [7:0] adr, pd, txd, rxd, rpd;
  logic [3:0] sel, ctx_seq;
  logic [1:0] ctx_type;
  logic [31:0] dat, rdat, rd, arp_ip, d0;
  logic [47:0] arp_mac, m;
  logic [15:0] len;
  logic [7:0] tx_b[$];
  int fail_count, samples_checked, arp_n, std_n, ver_n, rx_n, ctx_n, a, b;
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dift_framer #(.CTX_PERIOD(50), .VER_TICK(10)) i_dut (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .ARP_REQ_O(arp_req),
    .ARP_IP_O(arp_ip), .ARP_DONE_I(arp_done), .ARP_MAC_I(arp_mac),
    .CTX_REQ_O(ctx_req), .CTX_TYPE_O(ctx_type), .CTX_SEQ_O(ctx_seq),
    .TX_PL_DATA_I(pd), .TX_PL_VALID_I(pv), .TX_PL_LAST_I(pl),
    .TX_PL_LEN_I(len), .TX_PL_READY_O(ready), .ETH_TX_DATA_O(txd),
    .ETH_TX_VALID_O(txv), .ETH_TX_LAST_O(txl), .ETH_RX_DATA_I(rxd),
    .ETH_RX_VALID_I(rxv), .ETH_RX_LAST_I(rxl), .RX_PL_DATA_O(rpd),
    .RX_PL_VALID_O(rpv), .RX_PL_LAST_O(rpl), .RX_PL_CTX_O(rpc));
  dift_peer i_peer (.clk_i(clk), .arp_req_i(arp_req), .arp_done_o(arp_done),
    .arp_mac_o(arp_mac), .rx_data_o(rxd), .rx_valid_o(rxv), .rx_last_o(rxl));
  always @(posedge clk)
  begin
    arp_n += (arp_req === 1'b1);
    std_n += (ctx_req === 1'b1 && ctx_type === 2'h0);
    ver_n += (ctx_req === 1'b1 && ctx_type === 2'h1);
    rx_n += (rpv === 1'b1);
    ctx_n += (rpv === 1'b1 && rpc === 1'b1);
    if (txv === 1'b1)
      tx_b.push_back(txd);
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) fail_count++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic tx4;
    int n;
    n = 0;
    tx_b = {};
    len <= 16'h0004;
    pv <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      pd <= 8'hB0 + 8'(k);
      pl <= (k == 3);
      do @(posedge clk); while (ready !== 1'b1 && ++n < 200);
    end
    if (n >= 200) fail_count++;
    pv <= 1'b0;
    pl <= 1'b0;
    repeat (4) @(posedge clk);
    m = {tx_b[0], tx_b[1], tx_b[2], tx_b[3], tx_b[4], tx_b[5]};
  endtask : tx4
  // Sender side: checksum filled, source port 0, length 4 + 8
  function automatic logic [367:0] frm(input logic [47:0] dm,
    input logic [31:0] ip, input logic [15:0] pt, input logic [7:0] p0);
    logic [31:0] s;
    s = 32'h12B35 + ip[31:16] + ip[15:0];
    s = s[15:0] + s[31:16];
    return {dm, 48'h020000000002, 32'h08004500, 32'h00200000, 32'h40004011,
      ~s[15:0], 32'h0A000002, ip, 16'h0000, pt, 32'h000C0000, p0, 24'h0};
  endfunction : frm
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial
  begin
    {rst, cyc, stb, we, pv, pl, adr, pd, len, dat} = '1;
    {cyc, stb, we, pv, pl} = '0;
    sel = 4'hF;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wb(0, REG_TX_PORTS, 0); chk(rd, 32'hC350C350);
    wb(0, REG_RX_PORT, 0); chk(rd, 32'h0000C350);
    wb(0, REG_VER_RATE, 0); chk(rd, 32'h0);
    wb(0, 8'h3C, 0); chk(rd, 32'h0);
    wb(1, REG_TX_PORTS, 32'h03FF0400);
    wb(0, REG_TX_PORTS, 0); chk(rd, 32'hC3500400);
    sel = 4'h3;
    wb(1, REG_TX_PORTS, 32'hFFFF0500);
    sel = 4'hF;
    wb(0, REG_TX_PORTS, 0); chk(rd, 32'hC3500500);
    wb(1, REG_RX_PORT, 32'h3FF);
    wb(1, REG_RX_PORT, 32'hFFFF);
    wb(0, REG_RX_PORT, 0); chk(rd, 32'hFFFF);
    wb(1, REG_OWN_MAC_HI, 32'h02AA);
    wb(1, REG_OWN_MAC_LO, 32'hBBCCDD01);
    wb(1, REG_OWN_IP, 32'h0A000001);
    wb(1, REG_DST_IP, 32'h0A000002);
    wb(1, REG_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    chk(arp_n, 1);
    chk(arp_ip, 32'h0A000002);
    wb(0, REG_STATUS, 0); chk(rd & 32'h1, 32'h1);
    tx4();
    chk(tx_b.size(), 46);
    chk(m, 48'h025A00000007);
    chk({tx_b[12], tx_b[13], tx_b[14]}, 24'h080045);
    chk({tx_b[34], tx_b[35], tx_b[36], tx_b[37]}, 32'hC3500500);
    chk({tx_b[38], tx_b[39]}, 16'h000C);
    d0 = 0;
    for (int i = 14; i < 34; i += 2)
      d0 += {tx_b[i], tx_b[i+1]};
    d0 = d0[15:0] + d0[31:16];
    d0 = d0[15:0] + d0[31:16];
    chk(d0[15:0], 16'hFFFF);
    wb(1, REG_CTRL, 0);
    wb(1, REG_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    chk(arp_n, 2);
    wb(1, REG_CTRL, 0);
    wb(1, REG_DST_IP, 32'hEF000001);
    wb(1, REG_CTRL, 32'h7);
    repeat (20) @(posedge clk);
    chk(arp_n, 2);
    tx4();
    chk(m, 48'h01005E000001);
    a = rx_n;
    i_peer.send(frm(48'h02AABBCCDD01, 32'h0A000001, 16'hFFFF, 8'h18));
    chk(rx_n - a, 0);
    wb(0, REG_RX_DROPS, 0);
    d0 = rd;
    i_peer.send(frm(48'h02AABBCCDD01, 32'h0A000001, 16'hFFFF, 8'h40));
    chk(rx_n - a, 4);
    chk(ctx_n, 4);
    i_peer.send(frm(48'h02AABBCCDD01, 32'h0A000001, 16'hFFFF, 8'h18));
    chk(rx_n - a, 8);
    i_peer.send(frm(48'h02AABBCCDD02, 32'h0A000001, 16'hFFFF, 8'h18));
    i_peer.send(frm(48'h02AABBCCDD01, 32'h0A000009, 16'hFFFF, 8'h18));
    i_peer.send(frm(48'h02AABBCCDD01, 32'h0A000001, 16'hC350, 8'h18));
    chk(rx_n - a, 8);
    wb(0, REG_RX_DROPS, 0); chk(rd - d0, 3);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wb(1, REG_CTRL, 32'h3);
    wb(1, REG_VER_RATE, 32'd101);
    wb(0, REG_VER_RATE, 0); chk(rd, 32'h0);
    repeat (60) @(posedge clk);
    a = std_n;
    b = ver_n;
    repeat (500) @(posedge clk);
    chk(std_n - a, 10);
    chk(ver_n - b, 0);
    wb(1, REG_VER_RATE, 32'h64);
    repeat (20) @(posedge clk);
    b = ver_n;
    repeat (500) @(posedge clk);
    chk(ver_n - b >= 40, 1);
    wrap_up();
  end
endmodule : dift_framer_tb
